// ===== include/pap_pkg.sv
/*
  Shared constants and types of the per-phase active power datapath:
  sample timing, fixed-point layout, filter shifts, register indices,
  carrier structs and the state records of both modules.
  Assumes a 10 MHz core clock and a word-wide register port in front.
*/
package pap_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int US_PER_MS = 1000;
  localparam int SAMPLE_PERIOD_US = 125;
  localparam int TICK_CYCLES = (CLK_HZ / HZ_PER_MHZ) * SAMPLE_PERIOD_US;
  localparam int TICK_W = 11;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int SAMPLES_PER_MS = US_PER_MS / SAMPLE_PERIOD_US;

  // ----------------------------------------------------------------
  // filter settling, one-pole time constant from settle / taus
  // ----------------------------------------------------------------
  localparam int SETTLE_TAUS = 5;
  localparam int LPF_SETTLE_STD_MS = 650;      // about 65 dB ripple rejection
  localparam int LPF_SETTLE_STRONG_MS = 1300;  // about 128 dB ripple rejection
  localparam int FUND_SETTLE_63_MS = 375;
  localparam int FUND_SETTLE_FULL_MS = 875;
  localparam logic [3:0] LPF_SHIFT_STD =
    4'($clog2(LPF_SETTLE_STD_MS * SAMPLES_PER_MS / SETTLE_TAUS + 1) - 1);
  localparam logic [3:0] LPF_SHIFT_STRONG =
    4'($clog2(LPF_SETTLE_STRONG_MS * SAMPLES_PER_MS / SETTLE_TAUS + 1) - 1);
  localparam logic [3:0] FUND_SHIFT_50 =
    4'($clog2(FUND_SETTLE_FULL_MS * SAMPLES_PER_MS / SETTLE_TAUS + 1) - 1);
  localparam logic [3:0] FUND_SHIFT_60 = FUND_SHIFT_50 - 4'h1;

  // ----------------------------------------------------------------
  // fixed point
  // ----------------------------------------------------------------
  localparam int SMP_W = 24;
  localparam int WORD_W = 28;
  localparam int ACC_W = 40;
  localparam int FRAC_W = 12;
  localparam int PROD_SHIFT = 19;
  localparam int INST_SHIFT = 4;
  localparam int GAIN_FRAC = 23;
  localparam int FULL_SCALE_POWER_CONSTANT = 33_516_139;
  localparam logic signed [24:0] GAIN_ONE = 25'sh0800000;
  localparam logic [23:0] GAIN_HALF_DOWN = 24'hc00000;
  localparam logic [23:0] GAIN_HALF_UP = 24'h400000;
  localparam logic signed [55:0] SAT_HI = 56'sh00000007ffffff;
  localparam logic signed [55:0] SAT_LO = 56'shfffffff8000000;
  localparam logic [27:0] WORD_MAX = 28'h7ffffff;
  localparam logic [27:0] WORD_MIN = 28'h8000000;

  // ----------------------------------------------------------------
  // register word indices and control bits
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 6'h00;
  localparam logic [ADDR_W-1:0] REG_COMP_MODE = 6'h01;
  localparam logic [ADDR_W-1:0] REG_NOMINAL_VOLTAGE_LEVEL = 6'h02;
  localparam logic [ADDR_W-1:0] REG_GAIN_BASE = 6'h03;   // total a,b,c then fund a,b,c
  localparam logic [ADDR_W-1:0] REG_OFFSET_BASE = 6'h09; // total a,b,c then fund a,b,c
  localparam logic [ADDR_W-1:0] REG_INST_POWER_BASE = 6'h10;
  localparam logic [ADDR_W-1:0] REG_FUND_POWER_BASE = 6'h13;
  localparam logic [ADDR_W-1:0] NUM_COEF = 6'h06;
  localparam logic [ADDR_W-1:0] NUM_PHASE = 6'h03;
  localparam int FILTER_STRENGTH_BIT = 1;
  localparam int LINE_FREQ_BIT = 14;
  localparam logic [1:0] LAST_PHASE = 2'h2;
  localparam logic [2:0] FUND_COEF_OFS = 3'h3;

  // ----------------------------------------------------------------
  // memory of filter states, one word per phase: {fund, total}
  // ----------------------------------------------------------------
  localparam int MEM_DEPTH = 3;
  localparam int MEM_W = 2 * ACC_W;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][SMP_W-1:0] volt;
    logic [2:0][SMP_W-1:0] curr;
  } pap_samples_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } pap_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MUL = 4'h2,
    ST_FILT = 4'h4,
    ST_CORR = 4'h8
  } pap_fsm_t;

  typedef struct packed {
    pap_fsm_t fsm;
    logic [TICK_W-1:0] tick_cnt;
    logic [1:0] ph;
    pap_samples_t smp;
    logic [WORD_W-1:0] x;
    logic [WORD_W-1:0] y_tot;
    logic [WORD_W-1:0] y_fund;
    logic filter_strength_select;
    logic line_frequency_select;
    logic [23:0] nominal_voltage_level;
    logic [5:0][23:0] gain;
    logic [5:0][23:0] offs;
    logic [2:0][23:0] inst_power;
    logic [2:0][23:0] fund_power;
    logic [31:0] rdata;
    logic rvalid;
    logic update;
  } pap_st_t;

  typedef struct packed {
    logic [MEM_DEPTH-1:0][MEM_W-1:0] word;
    logic [MEM_W-1:0] rdata;
  } pap_mem_st_t;

endpackage

// ===== core/pap_state_mem.sv
/*
  Small memory of per-phase filter accumulators with a registered read.
  Assumes one access per cycle from the datapath sequencer.
*/
`timescale 1ns/1ps
`default_nettype none

module pap_state_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic re,
  input wire logic [1:0] addr,
  input wire logic [pap_pkg::MEM_W-1:0] wdata,
  output logic [pap_pkg::MEM_W-1:0] rdata
);

  pap_pkg::pap_mem_st_t m_r;
  pap_pkg::pap_mem_st_t m_nxt;

  // read first, a read returns the old word one cycle later
  always_comb begin
    m_nxt = m_r;
    if (we) begin
      m_nxt.word[addr] = wdata;
    end
    if (re) begin
      m_nxt.rdata = m_r.word[addr];
    end
  end

  // reset clears the filters so outputs start from zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      m_r <= '0;
    end else begin
      m_r <= m_nxt;
    end
  end

  assign rdata = m_r.rdata;

endmodule

`default_nettype wire

// ===== core/pap_datapath.sv
/*
  Per-phase active power datapath: multiplier, power low-pass filters,
  gain and offset correction, and the register port that serves them.
  Assumes voltage and current samples come from logic on clk and that a
  serial-port front end turns transfers into word requests.
*/
`timescale 1ns/1ps
`default_nettype none

module pap_datapath (
  input wire logic clk,
  input wire logic nrst,
  input wire pap_pkg::pap_samples_t samples,
  input wire pap_pkg::pap_req_t req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic power_update
);

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------

  // clamp a wide signed value to the 28-bit internal word
  function automatic logic [27:0] pap_sat28(input logic signed [55:0] v);
    if (v > pap_pkg::SAT_HI) begin
      return pap_pkg::WORD_MAX;
    end else if (v < pap_pkg::SAT_LO) begin
      return pap_pkg::WORD_MIN;
    end
    return v[27:0];
  endfunction

  // one-pole low-pass: acc += (x - acc) >> k, acc keeps FRAC_W guard bits
  function automatic logic [39:0] pap_lpf(input logic [39:0] acc, input logic [27:0] x,
                                          input logic [3:0] k);
    logic signed [40:0] tgt;
    logic signed [40:0] diff;
    logic signed [40:0] sum;
    tgt = $signed({x[27], x, {pap_pkg::FRAC_W{1'b0}}});
    diff = tgt - $signed({acc[39], acc});
    sum = $signed({acc[39], acc}) + (diff >>> k);
    return sum[39:0];
  endfunction

  // gain (1 + g/2^23) then offset, clamped
  function automatic logic [27:0] pap_correct(input logic [27:0] y, input logic [23:0] g,
                                              input logic [23:0] os);
    logic signed [24:0] fac;
    logic signed [52:0] p;
    logic signed [55:0] r;
    fac = $signed({g[23], g}) + pap_pkg::GAIN_ONE;
    p = $signed(y) * fac;
    r = 56'(p >>> pap_pkg::GAIN_FRAC) + 56'($signed(os));
    return pap_sat28(r);
  endfunction

  // signed 24-bit register as a 32-bit word: 28-bit sign extension, zero top
  function automatic logic [31:0] pap_pad28(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pap_pkg::pap_st_t s_r;
  pap_pkg::pap_st_t s_nxt;
  logic mem_we;
  logic mem_re;
  logic [pap_pkg::MEM_W-1:0] mem_wdata;
  logic [pap_pkg::MEM_W-1:0] mem_rdata;
  logic signed [47:0] prod;
  logic [39:0] acc_tot;
  logic [39:0] acc_fund;
  logic [3:0] tot_shift;
  logic [3:0] fund_shift;
  logic fund_ok;
  logic [2:0] ci;
  logic [2:0] fi;
  logic [27:0] c_tot;
  logic [27:0] c_fund;

  // ----------------------------------------------------------------
  // next state: sequencer, datapath and register port
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.update = 1'b0;
    ci = {1'b0, s_r.ph};
    fi = {1'b0, s_r.ph} + pap_pkg::FUND_COEF_OFS;
    tot_shift = s_r.filter_strength_select ? pap_pkg::LPF_SHIFT_STRONG
                                           : pap_pkg::LPF_SHIFT_STD;
    fund_shift = s_r.line_frequency_select ? pap_pkg::FUND_SHIFT_60
                                           : pap_pkg::FUND_SHIFT_50;
    // an unprogrammed level keeps the fundamental path decaying to zero
    fund_ok = $signed(s_r.nominal_voltage_level) > 0;
    prod = $signed(s_r.smp.volt[s_r.ph]) * $signed(s_r.smp.curr[s_r.ph]);
    acc_tot = pap_lpf(mem_rdata[39:0], s_r.x, tot_shift);
    acc_fund = pap_lpf(mem_rdata[79:40], fund_ok ? s_r.x : '0, fund_shift);
    c_tot = pap_correct(s_r.y_tot, s_r.gain[ci], s_r.offs[ci]);
    c_fund = pap_correct(s_r.y_fund, s_r.gain[fi], s_r.offs[fi]);
    mem_re = s_r.fsm == pap_pkg::ST_MUL;
    mem_we = s_r.fsm == pap_pkg::ST_FILT;
    mem_wdata = {acc_fund, acc_tot};

    // free-running sample tick, independent of the sequencer
    if (s_r.tick_cnt == pap_pkg::TICK_LAST) begin
      s_nxt.tick_cnt = '0;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end

    // three phases walked one after another, 9 cycles of a 1250 tick
    case (s_r.fsm)
      pap_pkg::ST_IDLE: begin
        if (s_r.tick_cnt == pap_pkg::TICK_LAST) begin
          s_nxt.smp = samples;
          s_nxt.ph = '0;
          s_nxt.fsm = pap_pkg::ST_MUL;
        end
      end
      pap_pkg::ST_MUL: begin
        // full-scale in-phase product lands just under the 28-bit clamp, at 2^27 - 32
        s_nxt.x = pap_sat28(56'(prod >>> pap_pkg::PROD_SHIFT));
        s_nxt.fsm = pap_pkg::ST_FILT;
      end
      pap_pkg::ST_FILT: begin
        s_nxt.y_tot = acc_tot[39:12];
        s_nxt.y_fund = acc_fund[39:12];
        s_nxt.fsm = pap_pkg::ST_CORR;
      end
      pap_pkg::ST_CORR: begin
        s_nxt.inst_power[s_r.ph] = c_tot[27:pap_pkg::INST_SHIFT];
        s_nxt.fund_power[s_r.ph] = c_fund[27:pap_pkg::INST_SHIFT];
        if (s_r.ph == pap_pkg::LAST_PHASE) begin
          s_nxt.fsm = pap_pkg::ST_IDLE;
          s_nxt.update = 1'b1;
        end else begin
          s_nxt.ph = s_r.ph + 1'b1;
          s_nxt.fsm = pap_pkg::ST_MUL;
        end
      end
      default: begin
        s_nxt.fsm = pap_pkg::ST_IDLE;
      end
    endcase

    // register writes; coefficients take effect at the next phase pass
    if (req.wr) begin
      if (req.addr == pap_pkg::REG_CONFIG) begin
        s_nxt.filter_strength_select = req.wdata[pap_pkg::FILTER_STRENGTH_BIT];
      end else if (req.addr == pap_pkg::REG_COMP_MODE) begin
        s_nxt.line_frequency_select = req.wdata[pap_pkg::LINE_FREQ_BIT];
      end else if (req.addr == pap_pkg::REG_NOMINAL_VOLTAGE_LEVEL) begin
        s_nxt.nominal_voltage_level = req.wdata[23:0];
      end else if (req.addr >= pap_pkg::REG_GAIN_BASE &&
                   req.addr < pap_pkg::REG_GAIN_BASE + pap_pkg::NUM_COEF) begin
        s_nxt.gain[3'(req.addr - pap_pkg::REG_GAIN_BASE)] = req.wdata[23:0];
      end else if (req.addr >= pap_pkg::REG_OFFSET_BASE &&
                   req.addr < pap_pkg::REG_OFFSET_BASE + pap_pkg::NUM_COEF) begin
        s_nxt.offs[3'(req.addr - pap_pkg::REG_OFFSET_BASE)] = req.wdata[23:0];
      end
    end

    // register reads answer one cycle later; unmapped words read zero
    if (req.rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = '0;
      if (req.addr == pap_pkg::REG_CONFIG) begin
        s_nxt.rdata[pap_pkg::FILTER_STRENGTH_BIT] = s_r.filter_strength_select;
      end else if (req.addr == pap_pkg::REG_COMP_MODE) begin
        s_nxt.rdata[pap_pkg::LINE_FREQ_BIT] = s_r.line_frequency_select;
      end else if (req.addr == pap_pkg::REG_NOMINAL_VOLTAGE_LEVEL) begin
        s_nxt.rdata = pap_pad28(s_r.nominal_voltage_level);
      end else if (req.addr >= pap_pkg::REG_GAIN_BASE &&
                   req.addr < pap_pkg::REG_GAIN_BASE + pap_pkg::NUM_COEF) begin
        s_nxt.rdata = pap_pad28(s_r.gain[3'(req.addr - pap_pkg::REG_GAIN_BASE)]);
      end else if (req.addr >= pap_pkg::REG_OFFSET_BASE &&
                   req.addr < pap_pkg::REG_OFFSET_BASE + pap_pkg::NUM_COEF) begin
        s_nxt.rdata = pap_pad28(s_r.offs[3'(req.addr - pap_pkg::REG_OFFSET_BASE)]);
      end else if (req.addr >= pap_pkg::REG_INST_POWER_BASE &&
                   req.addr < pap_pkg::REG_INST_POWER_BASE + pap_pkg::NUM_PHASE) begin
        s_nxt.rdata = {8'h00, s_r.inst_power[2'(req.addr - pap_pkg::REG_INST_POWER_BASE)]};
      end else if (req.addr >= pap_pkg::REG_FUND_POWER_BASE &&
                   req.addr < pap_pkg::REG_FUND_POWER_BASE + pap_pkg::NUM_PHASE) begin
        s_nxt.rdata = {8'h00, s_r.fund_power[2'(req.addr - pap_pkg::REG_FUND_POWER_BASE)]};
      end
    end
  end

  // single register stage for all state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '{fsm: pap_pkg::ST_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // filter state memory
  // ----------------------------------------------------------------
  pap_state_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .we(mem_we),
    .re(mem_re),
    .addr(s_r.ph),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign reg_rdata = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;
  assign power_update = s_r.update;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // cycles since the last update pulse, for the period check
  logic [pap_pkg::TICK_W-1:0] gap_cnt;
  logic gap_seen;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gap_cnt <= '0;
      gap_seen <= 1'b0;
    end else if (s_r.update) begin
      gap_cnt <= '0;
      gap_seen <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  AST_UPDATE_PERIOD: assert property (s_r.update && gap_seen |-> gap_cnt == pap_pkg::TICK_LAST)
    else $error("power update period is not one sample tick");
  AST_PRODUCT: assert property (s_r.fsm == pap_pkg::ST_MUL |=>
      s_r.x == pap_sat28(56'($past(prod) >>> pap_pkg::PROD_SHIFT)))
    else $error("product word does not match the latched samples");
  AST_FILT_STD: assert property (mem_we && !s_r.filter_strength_select |->
      mem_wdata[39:0] == pap_lpf(mem_rdata[39:0], s_r.x, pap_pkg::LPF_SHIFT_STD))
    else $error("standard filter step wrong");
  AST_FILT_STRONG: assert property (mem_we && s_r.filter_strength_select |->
      mem_wdata[39:0] == pap_lpf(mem_rdata[39:0], s_r.x, pap_pkg::LPF_SHIFT_STRONG))
    else $error("strong filter step wrong");
  AST_FUND_FILT: assert property (mem_we |-> mem_wdata[79:40] == pap_lpf(mem_rdata[79:40],
      fund_ok ? s_r.x : '0, s_r.line_frequency_select ? pap_pkg::FUND_SHIFT_60 : pap_pkg::FUND_SHIFT_50))
    else $error("fundamental filter step wrong");
  AST_INST_STORE: assert property (s_r.fsm == pap_pkg::ST_CORR && s_r.ph == 2'h0 |=>
      s_r.inst_power[0] == $past(c_tot[27:4]))
    else $error("phase a power not stored from corrected total");
  AST_FUND_STORE: assert property (s_r.fsm == pap_pkg::ST_CORR && s_r.ph == 2'h1 |=>
      s_r.fund_power[1] == $past(pap_correct(s_r.y_fund, s_r.gain[4], s_r.offs[4]) >> 4))
    else $error("phase b fundamental power does not use its own coefficients");
  AST_READ_PAD24: assert property ($past(req.rd && req.addr == pap_pkg::REG_INST_POWER_BASE) |->
      reg_rvalid && reg_rdata == {8'h00, $past(s_r.inst_power[0])})
    else $error("power register read is not zero padded");
  AST_READ_PAD28: assert property ($past(req.rd && req.addr == pap_pkg::REG_NOMINAL_VOLTAGE_LEVEL) |->
      reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}})
    else $error("signed register read is not sign extended");
  AST_GAIN_HALF: assert property (s_r.fsm == pap_pkg::ST_CORR && s_r.ph == 2'h0 &&
      s_r.gain[0] == pap_pkg::GAIN_HALF_DOWN && s_r.offs[0] == '0 |=>
      s_r.inst_power[0] == {$past(s_r.y_tot[27]), $past(s_r.y_tot[27:5])})
    else $error("half gain does not halve the power");
  AST_OFFSET: assert property (s_r.fsm == pap_pkg::ST_CORR && s_r.ph == 2'h2 &&
      s_r.y_tot == '0 && s_r.gain[2] == '0 |=>
      s_r.inst_power[2] == {{4{$past(s_r.offs[2][23])}}, $past(s_r.offs[2][23:4])})
    else $error("offset not added to zero power");
  AST_NO_WRAP: assert property (s_r.fsm == pap_pkg::ST_CORR && s_r.ph == 2'h0 &&
      !s_r.y_tot[27] && s_r.offs[0] == '0 |=> !s_r.inst_power[0][23])
    else $error("positive power wrapped negative");

  COV_STRONG_PASS: cover property (s_r.filter_strength_select && s_r.update);
  COV_HALF_UP: cover property (s_r.fsm == pap_pkg::ST_CORR && s_r.gain[0] == pap_pkg::GAIN_HALF_UP);
  COV_SAT: cover property (s_r.fsm == pap_pkg::ST_CORR && c_tot == pap_pkg::WORD_MAX);
  COV_READ_WRITE: cover property (req.wr ##1 req.rd ##1 reg_rvalid);

endmodule

`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench of the per-phase active power datapath: register port
  reads against a shadow copy, and a reference model of the multiply, filter
  and correction chain checked on every pass.
  Assumes pap_pkg and the datapath module are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------
  localparam longint HI = 64'sh0000000007ffffff;
  logic clk;
  logic nrst;
  pap_pkg::pap_samples_t smp;
  pap_pkg::pap_req_t req;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic power_update;
  int num_errors;
  int tests_run;
  int cyc;
  int last_upd;
  logic [31:0] seed;
  logic [31:0] sh [64];    // shadow of written words
  logic [23:0] inst [6];   // model powers: total a..c, fund a..c
  longint acc [6];
  logic [31:0] exp_q [$];
  int due_q [$];

  pap_datapath i_pap_datapath (.clk(clk), .nrst(nrst), .samples(smp), .req(req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .power_update(power_update));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic longint sat(longint v);
    if (v > HI) return HI;
    if (v < -HI - 1) return -HI - 1;
    return v;
  endfunction

  // expected read word, worked out from the shadow and the model
  function automatic logic [31:0] exp_rd(int a);
    if (a == 0) return {30'h0, sh[0][1], 1'b0};
    if (a == 1) return sh[1] & 32'h00004000;
    if (a >= 2 && a <= 14) return {4'h0, {4{sh[a][23]}}, sh[a][23:0]};
    if (a >= 16 && a <= 21) return {8'h00, inst[a-16]};
    return 32'h0;
  endfunction

  // one pass of the model; fund path sees no input while the level is not positive
  task automatic step();
    longint x;
    longint y;
    longint c;
    int k;
    for (int j = 0; j < 6; j++) begin
      x = sat((longint'($signed(smp.volt[j%3])) * longint'($signed(smp.curr[j%3]))) >>> 19);
      if (j >= 3 && $signed(sh[2][23:0]) <= 0) x = 0;
      k = (j < 3) ? (sh[0][1] ? 11 : 10) : (sh[1][14] ? 9 : 10);
      acc[j] = acc[j] + (((x <<< 12) - acc[j]) >>> k);
      y = acc[j] >>> 12;
      c = sat(((y * (64'sh800000 + longint'($signed(sh[3+j][23:0])))) >>> 23)
        + longint'($signed(sh[9+j][23:0])));
      inst[j] = c[27:4];
    end
  endtask

  // one request for exactly one cycle; a read notes its answer and due cycle
  task automatic issue(logic w, logic r, int a, logic [31:0] d);
    @(posedge clk);
    #1;
    req.wr = w;
    req.rd = r;
    req.addr = a[5:0];
    req.wdata = d;
    if (r) begin
      exp_q.push_back(exp_rd(a));
      due_q.push_back(cyc + 2);
    end
    if (w && a < 16) sh[a] = d;
  endtask

  task automatic rd(int a);
    seed = xs(seed);
    issue(1'b0, 1'b1, a, seed);
  endtask

  task automatic idle();
    @(posedge clk);
    #1;
    req = '0;
  endtask

  task automatic wait_upd();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (power_update !== 1'b1 && n < 2000);
    if (n >= 2000) chk("update wait", 32'h0, 32'h1);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the monitor pairs each answer with the oldest note; a late answer shows as two faults
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (nrst === 1'b1 && reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("rvalid", 32'h1, 32'h0);
      else begin
        chk("rdata", reg_rdata, exp_q.pop_front());
        chk("read latency", cyc, due_q.pop_front());
      end
    end else if (due_q.size() > 0 && due_q[0] == cyc) begin
      chk("rvalid", 32'h0, 32'h1);
      void'(exp_q.pop_front());
      void'(due_q.pop_front());
    end
    if (nrst === 1'b1 && power_update === 1'b1) begin
      if (last_upd > 0) chk("update period", cyc - last_upd, pap_pkg::TICK_CYCLES);
      last_upd = cyc;
    end
  end

  initial begin
    #3_000_000;
    num_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    smp = '0;
    req = '0;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    last_upd = 0;
    seed = 32'h00006e0d;
    for (int i = 0; i < 64; i++) sh[i] = 32'h0;
    for (int j = 0; j < 6; j++) begin
      acc[j] = 0;
      inst[j] = 24'h0;
    end
    // phase c starts with no current so its corrected power is the offset alone
    for (int j = 0; j < 3; j++) begin
      smp.volt[j] = 24'h7fffff;
      smp.curr[j] = (j == 1) ? 24'h800000 : ((j == 2) ? 24'h000000 : 24'h7fffff);
    end
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    // reset values, unmapped word included, reads back to back
    for (int a = 0; a < 23; a++) rd(a == 22 ? 63 : a);
    issue(1'b1, 1'b0, 16, 32'h00123456);
    issue(1'b1, 1'b0, 0, 32'hffffffff);
    issue(1'b1, 1'b0, 1, 32'hffffffff);
    rd(16);
    rd(0);
    rd(1);
    // signed coefficients read back sign-extended, upper write bits dropped
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      issue(1'b1, 1'b0, 3 + i, seed);
      rd(3 + i);
    end
    issue(1'b1, 1'b0, 3, 32'hffc00000);
    issue(1'b1, 1'b0, 4, 32'h00400000);
    issue(1'b1, 1'b0, 5, 32'h00000000);
    issue(1'b1, 1'b0, 9, 32'h00000000);
    issue(1'b1, 1'b0, 0, 32'h0);
    issue(1'b1, 1'b0, 1, 32'h0);
    idle();
    // passes: full-scale products first, then random samples, then the strong total filter and the 60 Hz fundamental shift
    for (int p = 0; p < 14; p++) begin
      wait_upd();
      step();
      for (int a = 16; a < 22; a++) rd(a);
      if (p == 1) issue(1'b1, 1'b0, 2, 32'h00078000);
      if (p == 7) begin
        issue(1'b1, 1'b0, 0, 32'h00000002);
        issue(1'b1, 1'b0, 1, 32'h00004000);
        rd(0);
        rd(2);
      end
      idle();
      if (p >= 3) begin
        for (int j = 0; j < 3; j++) begin
          seed = xs(seed);
          smp.volt[j] = {{4{seed[19]}}, seed[19:0]};
          smp.curr[j] = {{4{seed[31]}}, seed[31:12]};
        end
      end
    end
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule

`default_nettype wire
